// >>> logic/i2sa_top.v
// i2c slave front end: start/stop flags, address match, ack, read stretch
// assumes scl/sda pins are asynchronous; software bits arrive on clk_i
`timescale 1ns/1ns
`default_nettype none
`include "i2sa_regs.vh"

module i2sa_top (
	// clock and reset
	input  wire        clk_i,
	input  wire        reset_n_i,
	// bus pins
	input  wire        scl_i,
	input  wire        sda_i,
	output reg         scl_o,
	output reg         scl_oe_o,
	output reg         sda_o,
	output reg         sda_oe_o,
	// software control
	input  wire        module_enable_i,
	input  wire        ten_bit_select_i,
	input  wire        general_call_enable_i,
	input  wire        accept_all_addresses_bit_i,
	input  wire [9:0]  own_address_register_i,
	input  wire        receive_buffer_read_i,
	input  wire        clock_release_set_i,
	// software status
	output reg  [7:0]  receive_buffer_register_o,
	output reg         receive_buffer_full_flag_o,
	output reg         start_seen_o,
	output reg         stop_seen_o,
	output reg         data_not_address_o,
	output reg         direction_o,
	output reg         ten_bit_matched_flag_o,
	output reg         general_call_status_flag_o,
	output reg         clock_release_bit_o,
	output reg         slave_interrupt_pulse_o
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADR1 = 3'h1;
	localparam [2:0] ST_ADR2 = 3'h2;
	localparam [2:0] ST_ACK  = 3'h3;
	localparam [2:0] ST_DONE = 3'h4;

	// address classes of a 7-bit value
	localparam [1:0] CLS_GCALL = 2'h0;
	localparam [1:0] CLS_VALID = 2'h1;
	localparam [1:0] CLS_HDR   = 2'h2;
	localparam [1:0] CLS_RSV   = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	reg  [1:0] rst_sync_reg;
	wire       rst_n = rst_sync_reg[1];
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	// filtered level: follow the pin once stages two and three agree
	function i2sa_filt;
		input [2:0] s;
		input       cur;
		begin
			if (s[2] == s[1])
				i2sa_filt = s[2];
			else
				i2sa_filt = cur;
		end
	endfunction

	// a change counts only once stages two and three agree, filtering glitches
	// bit 1 carries scl, bit 0 carries sda
	wire [1:0] pin_raw = {scl_i, sda_i};
	wire [1:0] pin_new;
	wire [1:0] pin_lvl;
	genvar     g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_pin
			reg [2:0] sync_reg;
			reg       lvl_reg;
			always @(posedge clk_i or negedge rst_n) begin
				if (!rst_n) begin
					sync_reg <= 3'h7;
					lvl_reg  <= 1'b1;
				end else begin
					sync_reg <= {sync_reg[1:0], pin_raw[g]};
					lvl_reg  <= pin_new[g];
				end
			end
			assign pin_new[g] = i2sa_filt(sync_reg, lvl_reg);
			assign pin_lvl[g] = lvl_reg;
		end
	endgenerate

	wire scl_reg = pin_lvl[1];
	wire sda_reg = pin_lvl[0];
	wire scl_new = pin_new[1];
	wire sda_new = pin_new[0];
	wire scl_rise = scl_new & ~scl_reg;
	wire scl_fall = ~scl_new & scl_reg;
	wire start_ev = scl_reg & scl_new & sda_reg & ~sda_new;
	wire stop_ev  = scl_reg & scl_new & ~sda_reg & sda_new;

	////////////////////////////////////////////////////////////////////////////
	// address classification
	function [1:0] i2sa_class;
		input [6:0] a;
		begin
			if (a == `I2SA_GCALL_ADDR)
				i2sa_class = CLS_GCALL;
			else if (a >= `I2SA_VALID_LO && a <= `I2SA_VALID_HI)
				i2sa_class = CLS_VALID;
			else if (a >= `I2SA_HDR_LO && a <= `I2SA_HDR_HI)
				i2sa_class = CLS_HDR;
			else
				i2sa_class = CLS_RSV;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// receiver and matcher
	reg  [2:0] state_reg;
	reg  [7:0] shift_reg;
	reg  [3:0] bit_cnt_reg;
	reg        hdr_seen_reg;
	reg        read_hold_reg;
	reg        ack_drive_reg;

	wire [7:0] rx_byte  = shift_reg;
	wire [1:0] cls      = i2sa_class(rx_byte[7:1]);
	wire       gcall    = general_call_enable_i && cls == CLS_GCALL && !rx_byte[0];
	wire       match7   = rx_byte[7:1] == own_address_register_i[6:0];
	wire       hdr_ok   = rx_byte[7:3] == `I2SA_HDR_PATTERN
	                      && rx_byte[2:1] == own_address_register_i[9:8];
	wire       low_ok   = rx_byte == own_address_register_i[7:0];
	wire       byte_end = scl_fall && bit_cnt_reg == `I2SA_BITS_PER_BYTE;

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg                  <= ST_IDLE;
			shift_reg                  <= 8'h00;
			bit_cnt_reg                <= 4'h0;
			hdr_seen_reg               <= 1'b0;
			read_hold_reg              <= 1'b0;
			ack_drive_reg              <= 1'b0;
			start_seen_o               <= `I2SA_RESET_FLAGS;
			stop_seen_o                <= `I2SA_RESET_FLAGS;
			receive_buffer_register_o  <= 8'h00;
			receive_buffer_full_flag_o <= `I2SA_RESET_FLAGS;
			data_not_address_o         <= `I2SA_RESET_FLAGS;
			direction_o                <= `I2SA_RESET_FLAGS;
			ten_bit_matched_flag_o     <= `I2SA_RESET_FLAGS;
			general_call_status_flag_o <= `I2SA_RESET_FLAGS;
			clock_release_bit_o        <= `I2SA_RESET_RELEASE;
			slave_interrupt_pulse_o    <= 1'b0;
		end else if (!module_enable_i) begin
			state_reg              <= ST_IDLE;
			hdr_seen_reg           <= 1'b0;
			ack_drive_reg          <= 1'b0;
			start_seen_o           <= 1'b0;
			stop_seen_o            <= 1'b0;
			clock_release_bit_o    <= `I2SA_RESET_RELEASE;
			slave_interrupt_pulse_o <= 1'b0;
		end else begin
			slave_interrupt_pulse_o <= 1'b0;
			// a read in the same cycle as a new byte loses: the load wins
			if (receive_buffer_read_i)
				receive_buffer_full_flag_o <= 1'b0;
			if (clock_release_set_i)
				clock_release_bit_o <= 1'b1;
			if (scl_rise) begin
				shift_reg   <= {shift_reg[6:0], sda_new};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			case (state_reg)
			ST_ADR1, ST_ADR2: begin
				if (byte_end) begin
					receive_buffer_register_o  <= rx_byte;
					receive_buffer_full_flag_o <= 1'b1;
					bit_cnt_reg                <= 4'h0;
					if (state_reg == ST_ADR2) begin
						if (low_ok || accept_all_addresses_bit_i) begin
							ten_bit_matched_flag_o <= 1'b1;
							hdr_seen_reg           <= 1'b1;
							ack_drive_reg          <= 1'b1;
							state_reg              <= ST_ACK;
						end else
							state_reg <= ST_DONE;
					end else if (accept_all_addresses_bit_i || gcall) begin
						general_call_status_flag_o <= gcall;
						data_not_address_o         <= 1'b0;
						direction_o                <= rx_byte[0] & ~gcall;
						read_hold_reg              <= rx_byte[0] & ~gcall;
						ack_drive_reg              <= 1'b1;
						state_reg                  <= ST_ACK;
					end else if (ten_bit_select_i) begin
						if (hdr_ok && (!rx_byte[0] || hdr_seen_reg)) begin
							data_not_address_o <= 1'b0;
							direction_o        <= rx_byte[0];
							read_hold_reg      <= rx_byte[0];
							ack_drive_reg      <= 1'b1;
							state_reg          <= ST_ACK;
						end else
							state_reg <= ST_DONE;
					end else if (match7 && cls != CLS_GCALL) begin
						data_not_address_o <= 1'b0;
						direction_o        <= rx_byte[0];
						read_hold_reg      <= rx_byte[0];
						ack_drive_reg      <= 1'b1;
						state_reg          <= ST_ACK;
					end else
						state_reg <= ST_DONE;
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					// ninth falling edge ends the acknowledge slot
					ack_drive_reg           <= 1'b0;
					slave_interrupt_pulse_o <= 1'b1;
					bit_cnt_reg             <= 4'h0;
					if (read_hold_reg)
						clock_release_bit_o <= 1'b0;
					read_hold_reg <= 1'b0;
					if (ten_bit_select_i && !hdr_seen_reg && !general_call_status_flag_o
					    && !accept_all_addresses_bit_i)
						state_reg <= ST_ADR2;
					else
						state_reg <= ST_DONE;
				end
			end
			ST_IDLE, ST_DONE: ;
			default: state_reg <= ST_IDLE;
			endcase
			// a repeated start restarts matching; stop clears the header memory
			if (start_ev) begin
				start_seen_o <= 1'b1;
				stop_seen_o  <= 1'b0;
				state_reg    <= ST_ADR1;
				bit_cnt_reg  <= 4'h0;
				ack_drive_reg <= 1'b0;
				ten_bit_matched_flag_o <= 1'b0;
				if (!ten_bit_matched_flag_o)
					hdr_seen_reg <= 1'b0;
			end else if (stop_ev) begin
				stop_seen_o  <= 1'b1;
				start_seen_o <= 1'b0;
				state_reg    <= ST_IDLE;
				hdr_seen_reg <= 1'b0;
				ack_drive_reg <= 1'b0;
				ten_bit_matched_flag_o <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// open-drain pin drivers: the low level is the only one ever driven
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_o    <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (!module_enable_i) begin
			scl_o    <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			// letting go of sda at a start or stop keeps the condition clean
			sda_o    <= 1'b0;
			sda_oe_o <= ack_drive_reg && !start_ev && !stop_ev;
			// hold only once scl is seen low, so no high phase is cut short
			scl_o    <= 1'b0;
			scl_oe_o <= !clock_release_bit_o && !scl_reg;
		end
	end

endmodule
`default_nettype wire

// >>> logic/i2sa_regs.vh
// constants for the i2c slave address detector
// assumes inclusion by bare name from the design file
`ifndef I2SA_REGS_VH
`define I2SA_REGS_VH
`define I2SA_HDR_PATTERN    5'h1e
`define I2SA_GCALL_ADDR     7'h00
`define I2SA_RSV_LO_TOP     7'h07
`define I2SA_VALID_LO       7'h08
`define I2SA_VALID_HI       7'h77
`define I2SA_HDR_LO         7'h78
`define I2SA_HDR_HI         7'h7b
`define I2SA_BITS_PER_BYTE  4'h8
`define I2SA_RESET_FLAGS    1'b0
`define I2SA_RESET_RELEASE  1'b1
`endif

// >>> sim/i2sa_chk.sv
// port checks for the slave address front end
// assumes a bind onto i2sa_top and one clock domain
`timescale 1ns/1ns
`default_nettype none
module i2sa_chk (
	input wire logic clk_i, reset_n_i, module_enable_i, receive_buffer_read_i,
	input wire logic sda_oe_o, scl_oe_o, start_seen_o, stop_seen_o, direction_o,
	input wire logic receive_buffer_full_flag_o, clock_release_bit_o, slave_interrupt_pulse_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_ack_end;
		$fell(sda_oe_o);
	endsequence
	a_flags_excl: assert property (!(start_seen_o && stop_seen_o))
		else $error("start and stop both set");
	a_off_clears: assert property (!module_enable_i |-> ##2 !(start_seen_o || stop_seen_o))
		else $error("flags kept while disabled");
	a_irq_single: assert property (slave_interrupt_pulse_o |=> !slave_interrupt_pulse_o)
		else $error("interrupt too wide");
	a_irq_at_ack: assert property (s_ack_end |-> $past(slave_interrupt_pulse_o))
		else $error("no interrupt after ack");
	a_read_holds: assert property (
		slave_interrupt_pulse_o && direction_o |-> ##[0:2] !clock_release_bit_o)
		else $error("read match left clock released");
	a_scl_hold: assert property (scl_oe_o |-> !$past(clock_release_bit_o))
		else $error("scl held while released");
	a_full_on_ack: assert property ($rose(sda_oe_o) |-> ##[0:1] receive_buffer_full_flag_o)
		else $error("buffer not full at ack");
	a_full_clear: assert property (
		$fell(receive_buffer_full_flag_o) |-> $past(receive_buffer_read_i) || $past(receive_buffer_read_i, 2))
		else $error("full cleared without read");
endmodule
bind i2sa_top i2sa_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .module_enable_i(module_enable_i),
	.receive_buffer_read_i(receive_buffer_read_i), .sda_oe_o(sda_oe_o), .scl_oe_o(scl_oe_o),
	.start_seen_o(start_seen_o), .stop_seen_o(stop_seen_o), .direction_o(direction_o),
	.receive_buffer_full_flag_o(receive_buffer_full_flag_o), .clock_release_bit_o(clock_release_bit_o),
	.slave_interrupt_pulse_o(slave_interrupt_pulse_o));
`default_nettype wire

// >>> sim/i2sa_master.sv
// bus master model: 72 ns scl, both lines open drain with pull-ups
// assumes the bench ands its releases with the slave pull-downs
`timescale 1ns/1ns
`default_nettype none
module i2sa_master (
	input  wire logic scl_l_i,
	input  wire logic sda_l_i,
	output var logic  scl_m_o = 1'b1,
	output var logic  sda_m_o = 1'b1
);
	// high phase timed only once a stretching slave lets go
	task automatic hi(); scl_m_o = 1; wait (scl_l_i); #32; endtask
	task automatic lo(); scl_m_o = 0; #32; endtask
	// data moves while scl is low except in start and stop, so it is stable at the rise
	task automatic put(input logic v); sda_m_o = v; #8; endtask
	// #1 keeps the master's bus edges off the rising edges of the bench clock
	task automatic start(); #1; put(1); hi(); put(0); #24; lo(); endtask
	task automatic stop(); #1; put(0); hi(); put(1); #32; endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			put(b[i]);
			hi();
			lo();
		end
		put(1);
		hi();
		ack = !sda_l_i;
		lo();
	endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// bench: table of address cases, then disable and repeated start cases
// assumes the master model on the bus; software bits driven here
`timescale 1ns/1ns
`default_nettype none
module testbench;
	typedef struct packed {
		logic       ten, gc, all, two, a0, a1, dir, gcs;
		logic [9:0] own;
		logic [7:0] b0, b1;
	} i2sa_row_t;
	logic       clk_i = 0, reset_n_i = 0, en = 0, ten = 0, gc = 0, all = 0, rd = 0, rel = 0, ack;
	logic [9:0] own = 10'h000;
	wire        scl_m, sda_m, scl_oe, sda_oe, full, ss, ps, dna, dir, tbm, gcs, crel;
	wire [7:0]  rbuf;
	wire        irq, scl_do, sda_do;
	int         n_irq = 0, e_irq = 0;
	always @(posedge clk_i) if (irq) n_irq <= n_irq + 1;
	wire        scl = scl_m & ~scl_oe;
	wire        sda = sda_m & ~sda_oe;
	int         n_mismatch = 0, num_checks = 0;
	i2sa_row_t  r;
	// flags: ten gc all two ack0 ack1 dir gcs
	i2sa_row_t  rows [11] = '{{8'h08, 10'h0a5, 8'h4a, 8'h00}, {8'h0a, 10'h0a5, 8'h4b, 8'h00},
		{8'h10, 10'h0a5, 8'h4c, 8'h4a}, {8'h49, 10'h0a5, 8'h00, 8'h00},
		{8'h00, 10'h0a5, 8'h00, 8'h00}, {8'hc9, 10'h2a5, 8'h00, 8'h00},
		{8'h28, 10'h0a5, 8'hf8, 8'h00}, {8'h2a, 10'h0a5, 8'hf5, 8'h00},
		{8'h9c, 10'h2a5, 8'hf4, 8'ha5}, {8'h90, 10'h2a5, 8'hf2, 8'ha5},
		{8'h98, 10'h2a5, 8'hf4, 8'ha6}};
	i2sa_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda),
		.scl_o(scl_do), .sda_o(sda_do),
		.scl_oe_o(scl_oe), .sda_oe_o(sda_oe), .module_enable_i(en), .ten_bit_select_i(ten),
		.general_call_enable_i(gc), .accept_all_addresses_bit_i(all), .own_address_register_i(own),
		.receive_buffer_read_i(rd), .clock_release_set_i(rel), .receive_buffer_register_o(rbuf),
		.receive_buffer_full_flag_o(full), .start_seen_o(ss), .stop_seen_o(ps),
		.data_not_address_o(dna), .direction_o(dir), .ten_bit_matched_flag_o(tbm),
		.general_call_status_flag_o(gcs), .clock_release_bit_o(crel), .slave_interrupt_pulse_o(irq));
	i2sa_master u_mst (.scl_l_i(scl), .sda_l_i(sda), .scl_m_o(scl_m), .sda_m_o(sda_m));
	always #2 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic read_buf();
		@(posedge clk_i) rd <= 1;
		@(posedge clk_i) rd <= 0;
		settle();
		chk(full, 0);
	endtask
	task automatic release_bus();
		chk(crel, 0);
		#400;
		chk(scl_oe, 1);
		@(posedge clk_i) rel <= 1;
		@(posedge clk_i) rel <= 0;
		settle();
		chk(crel, 1);
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1;
		repeat (6) settle();
		chk({ss, ps, full, crel}, 4'h1);
		@(posedge clk_i) en <= 1;
		foreach (rows[i]) begin
			r = rows[i];
			@(posedge clk_i) {ten, gc, all, own} <= {r.ten, r.gc, r.all, r.own};
			u_mst.start();
			chk({ss, ps}, 2'h2);
			u_mst.wr(r.b0, ack);
			chk(ack, r.a0);
			if (r.a0)
				chk({rbuf, full, dna, dir, gcs}, {r.b0, 2'h2, r.dir, r.gcs});
			if (r.two) begin
				u_mst.wr(r.b1, ack);
				chk({ack, tbm}, {r.a1, r.a1});
			end
			if (r.dir)
				release_bus();
			read_buf();
			u_mst.stop();
			chk({ss, ps}, 2'h1);
			e_irq = e_irq + r.a0 + (r.two & r.a1);
			chk(n_irq, e_irq);
		end
		@(posedge clk_i) {en, all} <= 2'h0;
		settle();
		chk(ps, 0);
		@(posedge clk_i) en <= 1;
		u_mst.start();
		u_mst.wr(8'hf4, ack);
		u_mst.wr(8'ha5, ack);
		read_buf();
		u_mst.start();
		u_mst.wr(8'hf5, ack);
		chk({ack, dir, ss}, 3'h7);
		release_bus();
		u_mst.stop();
		e_irq = e_irq + 3;
		chk(n_irq, e_irq);
		chk({scl_do, sda_do}, 2'h0);
		conclude();
	end
endmodule
`default_nettype wire
